// ### status_regs_pkg.sv
// Package for the checksum and miscellaneous status register bank.
// Assumes 24-bit register words and 6-bit register indices.
`default_nettype none
package status_regs_pkg;
  localparam int unsigned REG_W = 24;
  localparam int unsigned ADDR_W = 6;
  // Register indices
  localparam logic [5:0] CHECKSUM_IDX = 6'h03;
  localparam logic [5:0] MISC_STATUS_IDX = 6'h04;
  localparam logic [5:0] INT_STATUS_IDX = 6'h01;
  // Reset values
  localparam logic [15:0] CHECKSUM_RESET = 16'hffff;
  localparam logic [23:0] MISC_STATUS_RESET = 24'h000000;
  // Field positions in the miscellaneous status word
  localparam int unsigned HOT_SHUTDOWN_POS = 0;
  localparam int unsigned HOT_WARNING_POS = 1;
  localparam int unsigned OVERVOLTAGE_POS = 2;
  localparam int unsigned UNDERVOLTAGE_POS = 3;
  localparam int unsigned BAND_A_POS = 4;
  localparam int unsigned BAND_B_POS = 6;
  localparam int unsigned SOURCE0_POS = 8;
  localparam int unsigned SOURCE1_POS = 9;
  localparam int unsigned SINK2_POS = 10;
  localparam int unsigned SINK3_POS = 11;
  localparam int unsigned CONV_FAULT_POS = 12;
  // Interrupt status bit for temperature warning changes
  localparam int unsigned HOT_WARNING_EVENT_POS = 5;
  // Band level encodings
  localparam logic [1:0] LEVEL_BELOW = 2'h0;
  localparam logic [1:0] LEVEL_BETWEEN = 2'h1;
  localparam logic [1:0] LEVEL_ABOVE = 2'h2;
endpackage : status_regs_pkg
`default_nettype wire

// ### band_classifier.sv
// Classifies a supply level against a low and a high threshold.
// Assumes both comparator inputs are already synchronised to clk.
`default_nettype none
module band_classifier (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic at_or_above_low,
  input wire logic at_or_above_high,
  output logic [1:0] level
);
  logic [1:0] level_r;
  logic [1:0] level_nxt;

  // High wins; code 3 never produced
  assign level_nxt = at_or_above_high ? status_regs_pkg::LEVEL_ABOVE :
                     at_or_above_low ? status_regs_pkg::LEVEL_BETWEEN :
                     status_regs_pkg::LEVEL_BELOW;

  // Registered so the field only changes on a clock edge
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      level_r <= status_regs_pkg::LEVEL_BELOW;
    end else begin
      level_r <= level_nxt;
    end
  end

  assign level = level_r;
endmodule : band_classifier
`default_nettype wire

// ### status_regs.sv
// Read-only checksum and miscellaneous status registers.
// Assumes analog conditions arrive asynchronously and are synchronised
// here; the checksum comes from same-clock logic with a valid strobe.
// Function
// [RL1] Checksum register returns the 16-bit CRC in bits 15-0, resets all ones.
// [RL2] Misc status shows non-switch conditions; bits 23-13 read zero.
// [RL3] Bit 12 reads one when the converter self-diagnostic found an error.
// [RL4] Bits 11 and 10 flag abnormal current sink on input 3 and 2.
// [RL5] Bits 9 and 8 flag abnormal current source on input 1 and 0.
// [RL6] Bits 7-6 encode supply against band A thresholds: 0,1,2; 3 unused.
// [RL7] Bits 5-4 encode supply against band B thresholds the same way.
// [RL8] Bit 3 reads one while supply is below under-voltage threshold.
// [RL9] Bit 2 reads one while supply is above over-voltage threshold.
// [RL10] Bit 1 reads one while junction is above warning temperature.
// [RL11] Bit 0 reads one while junction is above shutdown temperature.
// [RL12] Both registers are read only; misc status resets to zero.
// [RL13] Controller compares the checksum with its own calculation.
// [RL14] Warning set or clear also sets clear-on-read interrupt bit 5.
// [RL15] Misc status tracks live and is not altered by reading.
`default_nettype none
module status_regs (
  input wire logic clk,
  input wire logic reset_n,
  // Register access port
  input wire logic rd_en,
  input wire logic wr_en,
  input wire logic [5:0] addr,
  input wire logic [23:0] wr_data,
  output logic [23:0] rd_data,
  output logic rd_hit,
  // Checksum from the configuration CRC engine, same clock
  input wire logic crc_valid,
  input wire logic [15:0] crc_value,
  // Asynchronous condition inputs
  input wire logic conv_fault,
  input wire logic sink3_fault,
  input wire logic sink2_fault,
  input wire logic source1_fault,
  input wire logic source0_fault,
  input wire logic band_a_low_threshold,
  input wire logic band_a_high_threshold,
  input wire logic band_b_low_threshold,
  input wire logic band_b_high_threshold,
  input wire logic undervoltage_level,
  input wire logic overvoltage_level,
  input wire logic hot_warning_level,
  input wire logic hot_shutdown_level,
  // Clear-on-read temperature warning change flag
  output logic hot_warning_event
);
  localparam int unsigned NSYNC = 11;

  logic rst_meta_r;
  logic rst_sync_r;
  logic rst_n;
  logic [NSYNC-1:0] cond_raw;
  logic [NSYNC-1:0] cond_meta_r;
  logic [NSYNC-1:0] cond_sync_r;
  logic [NSYNC-1:0] cond_r;
  logic [15:0] checksum_r;
  logic [15:0] checksum_nxt;
  logic [1:0] band_a_level;
  logic [1:0] band_b_level;
  logic [23:0] misc_word;
  logic [23:0] checksum_word;
  logic [23:0] rd_data_r;
  logic [23:0] rd_data_nxt;
  logic rd_hit_r;
  logic warn_prev_r;
  logic warn_change;
  logic event_r;
  logic event_nxt;
  logic int_read;
  logic hit_checksum;
  logic hit_misc;
  logic hit_int;
  logic unused_wr;

  // Reset release through two flip-flops, assertion stays asynchronous
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      rst_meta_r <= 1'b0;
      rst_sync_r <= 1'b0;
    end else begin
      rst_meta_r <= 1'b1;
      rst_sync_r <= rst_meta_r;
    end
  end
  assign rst_n = rst_sync_r;

  // Gather the asynchronous conditions other than the temperature levels for one synchroniser bank
  assign cond_raw = {conv_fault, sink3_fault, sink2_fault, source1_fault,
                     source0_fault, band_a_low_threshold,
                     band_a_high_threshold, band_b_low_threshold,
                     band_b_high_threshold, undervoltage_level,
                     overvoltage_level};

  // Two-stage synchroniser per condition bit; third stage is the live copy
  genvar g;
  generate
    for (g = 0; g < NSYNC; g = g + 1) begin : g_sync
      always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
          cond_meta_r[g] <= 1'b0;
          cond_sync_r[g] <= 1'b0;
          cond_r[g] <= 1'b0;
        end else begin
          cond_meta_r[g] <= cond_raw[g];
          cond_sync_r[g] <= cond_meta_r[g];
          cond_r[g] <= cond_sync_r[g]; // RL15
        end
      end
    end
  endgenerate

  // Temperature levels kept apart so the warning edge detector sees
  // only settled copies
  logic [1:0] temp_meta_r;
  logic [1:0] temp_sync_r;
  logic [1:0] temp_r;
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      temp_meta_r <= 2'h0;
      temp_sync_r <= 2'h0;
      temp_r <= 2'h0;
    end else begin
      temp_meta_r <= {hot_warning_level, hot_shutdown_level};
      temp_sync_r <= temp_meta_r;
      temp_r <= temp_sync_r; // RL10 RL11
    end
  end

  // Supply band classification, one instance per band
  band_classifier u_band_a (
    .clk(clk),
    .rst_n(rst_n),
    .at_or_above_low(cond_r[5]),
    .at_or_above_high(cond_r[4]),
    .level(band_a_level)
  ); // RL6
  band_classifier u_band_b (
    .clk(clk),
    .rst_n(rst_n),
    .at_or_above_low(cond_r[3]),
    .at_or_above_high(cond_r[2]),
    .level(band_b_level)
  ); // RL7

  // Misc status word; reserved upper bits tied to zero
  always_comb begin
    misc_word = status_regs_pkg::MISC_STATUS_RESET; // RL2
    misc_word[status_regs_pkg::CONV_FAULT_POS] = cond_r[10]; // RL3
    misc_word[status_regs_pkg::SINK3_POS] = cond_r[9]; // RL4
    misc_word[status_regs_pkg::SINK2_POS] = cond_r[8]; // RL4
    misc_word[status_regs_pkg::SOURCE1_POS] = cond_r[7]; // RL5
    misc_word[status_regs_pkg::SOURCE0_POS] = cond_r[6]; // RL5
    misc_word[status_regs_pkg::BAND_B_POS +: 2] = band_a_level; // RL6
    misc_word[status_regs_pkg::BAND_A_POS +: 2] = band_b_level; // RL7
    misc_word[status_regs_pkg::UNDERVOLTAGE_POS] = cond_r[1]; // RL8
    misc_word[status_regs_pkg::OVERVOLTAGE_POS] = cond_r[0]; // RL9
    misc_word[status_regs_pkg::HOT_WARNING_POS] = temp_r[1]; // RL10
    misc_word[status_regs_pkg::HOT_SHUTDOWN_POS] = temp_r[0]; // RL11
  end

  // Checksum holds all ones until the engine reports a result
  assign checksum_nxt = crc_valid ? crc_value : checksum_r;
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      checksum_r <= status_regs_pkg::CHECKSUM_RESET; // RL1
    end else begin
      checksum_r <= checksum_nxt; // RL1
    end
  end
  assign checksum_word = {8'h00, checksum_r}; // RL1

  // Address decode
  assign hit_checksum = (addr == status_regs_pkg::CHECKSUM_IDX);
  assign hit_misc = (addr == status_regs_pkg::MISC_STATUS_IDX);
  assign hit_int = (addr == status_regs_pkg::INT_STATUS_IDX);
  assign int_read = rd_en && hit_int;

  // Warning changes in either direction raise the event flag;
  // a change in the same cycle as the clearing read wins
  assign warn_change = temp_r[1] ^ warn_prev_r;
  assign event_nxt = warn_change ? 1'b1 : (int_read ? 1'b0 : event_r);
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      warn_prev_r <= 1'b0;
      event_r <= 1'b0;
    end else begin
      warn_prev_r <= temp_r[1];
      event_r <= event_nxt; // RL14
    end
  end
  assign hot_warning_event = event_r;

  // Read data: one cycle after rd_en; unmapped reads return zero.
  // The interrupt index returns only the warning change bit here.
  always_comb begin
    rd_data_nxt = 24'h000000;
    if (hit_checksum) begin
      rd_data_nxt = checksum_word;
    end else if (hit_misc) begin
      rd_data_nxt = misc_word; // RL15
    end else if (hit_int) begin
      rd_data_nxt[status_regs_pkg::HOT_WARNING_EVENT_POS] = event_r;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rd_data_r <= 24'h000000;
      rd_hit_r <= 1'b0;
    end else begin
      rd_data_r <= rd_en ? rd_data_nxt : rd_data_r;
      rd_hit_r <= rd_en && (hit_checksum || hit_misc || hit_int);
    end
  end
  assign rd_data = rd_data_r;
  assign rd_hit = rd_hit_r;

  // Writes land nowhere: every field here is read only
  assign unused_wr = wr_en ^ (^wr_data); // RL12
endmodule : status_regs
`default_nettype wire

// ### status_regs_chk.sv
// Checker for the status register bank, watching its ports only.
// Assumes conditions settle within six edges of any change.
`default_nettype none
module status_regs_chk (
  input wire logic clk, reset_n, rd_en, wr_en, rd_hit, crc_valid,
  input wire logic [5:0] addr,
  input wire logic [23:0] wr_data, rd_data,
  input wire logic [15:0] crc_value,
  input wire logic conv_fault, sink3_fault, sink2_fault, source1_fault,
  input wire logic source0_fault, band_a_low_threshold,
  input wire logic band_a_high_threshold, band_b_low_threshold,
  input wire logic band_b_high_threshold, undervoltage_level,
  input wire logic overvoltage_level, hot_warning_level,
  input wire logic hot_shutdown_level, hot_warning_event
);
  logic [12:0] cond, prev_r, exp_w;
  logic [2:0] stab_r;
  logic [15:0] crc_r;
  logic int_rd;
  // Expected low misc bits, from last cycle's condition copy
  assign cond = {conv_fault, sink3_fault, sink2_fault, source1_fault,
    source0_fault, band_a_low_threshold, band_a_high_threshold,
    band_b_low_threshold, band_b_high_threshold, undervoltage_level,
    overvoltage_level, hot_warning_level, hot_shutdown_level};
  assign exp_w = {prev_r[12:8], prev_r[6] ? 2'h2 : {1'b0, prev_r[7]},
    prev_r[4] ? 2'h2 : {1'b0, prev_r[5]}, prev_r[3:0]};
  assign int_rd = rd_en && addr == status_regs_pkg::INT_STATUS_IDX;
  // Stable count hides values still crossing the input syncs
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      prev_r <= 13'h0000;
      stab_r <= 3'h0;
      crc_r <= 16'hffff;
    end else begin
      prev_r <= cond;
      stab_r <= (cond != prev_r) ? 3'h0 : stab_r + {2'h0, stab_r != 3'h7};
      crc_r <= crc_valid ? crc_value : crc_r;
    end
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);
  a_crc_word: assert property (
    rd_hit && $past(addr) == 6'h03 |-> rd_data == {8'h00, crc_r})
    else $error("checksum word wrong");
  a_misc_reserved: assert property (
    rd_hit && $past(addr) == 6'h04 |-> rd_data[23:13] == 11'h000)
    else $error("misc reserved bits set");
  a_fault_bits: assert property (
    rd_hit && $past(addr) == 6'h04 && stab_r == 3'h7
    |-> rd_data[12:8] == exp_w[12:8]) else $error("fault bits wrong");
  a_band_codes: assert property (
    rd_hit && $past(addr) == 6'h04 && stab_r == 3'h7
    |-> rd_data[7:4] == exp_w[7:4]) else $error("band codes wrong");
  a_level_bits: assert property (
    rd_hit && $past(addr) == 6'h04 && stab_r == 3'h7
    |-> rd_data[3:0] == exp_w[3:0]) else $error("level bits wrong");
  a_write_inert: assert property (
    wr_en && !rd_en |=> $stable(rd_data)) else $error("write moved data");
  a_event_set: assert property (
    $changed(hot_warning_level) |-> ##[3:5] hot_warning_event)
    else $error("warning change not flagged");
  a_event_hold: assert property (
    hot_warning_event && !int_rd |=> hot_warning_event)
    else $error("warning flag dropped");
  a_event_clear: assert property (
    int_rd && stab_r == 3'h7 |=> !hot_warning_event)
    else $error("warning flag not cleared");
endmodule : status_regs_chk
bind status_regs status_regs_chk status_regs_chk_inst (.clk, .reset_n,
  .rd_en, .wr_en, .rd_hit, .crc_valid, .addr, .wr_data, .rd_data,
  .crc_value, .conv_fault, .sink3_fault, .sink2_fault, .source1_fault,
  .source0_fault, .band_a_low_threshold, .band_a_high_threshold,
  .band_b_low_threshold, .band_b_high_threshold, .undervoltage_level,
  .overvoltage_level, .hot_warning_level, .hot_shutdown_level,
  .hot_warning_event);
`default_nettype wire

// ### mcu_model.sv
// Controller model issuing one register access at a time.
// Assumes a request is taken on the edge where rd_en or wr_en is high.
`default_nettype none
module mcu_model (
  input wire logic clk,
  input wire logic [23:0] rd_data,
  input wire logic rd_hit,
  output logic rd_en,
  output logic wr_en,
  output logic [5:0] addr,
  output logic [23:0] wr_data
);
  timeunit 1ns;
  timeprecision 1ps;
  // Idle bus from time zero
  initial begin
    rd_en = 1'b0;
    wr_en = 1'b0;
    addr = 6'h00;
    wr_data = 24'h000000;
  end
  // Held over the taking edge; lines scrambled once released
  task read_reg(input logic [5:0] a, output logic [23:0] d, output logic h);
    @(posedge clk);
    rd_en <= 1'b1;
    addr <= a;
    @(posedge clk);
    rd_en <= 1'b0;
    addr <= ~a;
    #1;
    d = rd_data;
    h = rd_hit;
  endtask : read_reg
  task write_reg(input logic [5:0] a, input logic [23:0] d);
    @(posedge clk);
    wr_en <= 1'b1;
    addr <= a;
    wr_data <= d;
    @(posedge clk);
    wr_en <= 1'b0;
    addr <= ~a;
    wr_data <= ~d;
  endtask : write_reg
  // Checksum against the controller's own figure
  task verify_crc(input logic [15:0] own, output logic ok);
    logic [23:0] d;
    logic h;
    read_reg(6'h03, d, h);
    ok = h && d === {8'h00, own};
  endtask : verify_crc
endmodule : mcu_model
`default_nettype wire

// ### checksum_and_misc_status_regs_test.sv
// Self-checking bench for the checksum and status register bank.
// Conditions driven directly; register traffic through mcu_model.
`default_nettype none
module checksum_and_misc_status_regs_test;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk, reset_n, rd_en, wr_en, rd_hit, crc_valid, hot_warning_event;
  logic hit, match;
  logic [5:0] addr;
  logic [23:0] wr_data, rd_data, got;
  logic [15:0] crc_value;
  logic [12:0] c;
  int bad_count, n_tests;
  // Condition word in 36:24, misc word it should give in 23:0
  logic [36:0] rows [16] = '{37'h0, 37'h1000001000, 37'h0800000800,
    37'h0400000400, 37'h0200000200, 37'h0100000100, 37'h0080000040,
    37'h00c0000080, 37'h0040000080, 37'h0020000010, 37'h0030000020,
    37'h0008000008, 37'h0004000004, 37'h0002000002, 37'h0001000001,
    37'h1fff001faf};
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  status_regs status_regs_inst (.clk, .reset_n, .rd_en, .wr_en, .addr,
    .wr_data, .rd_data, .rd_hit, .crc_valid, .crc_value, .conv_fault(c[12]),
    .sink3_fault(c[11]), .sink2_fault(c[10]), .source1_fault(c[9]),
    .source0_fault(c[8]), .band_a_low_threshold(c[7]),
    .band_a_high_threshold(c[6]), .band_b_low_threshold(c[5]),
    .band_b_high_threshold(c[4]), .undervoltage_level(c[3]),
    .overvoltage_level(c[2]), .hot_warning_level(c[1]),
    .hot_shutdown_level(c[0]), .hot_warning_event);
  mcu_model mcu_model_inst (.clk, .rd_data, .rd_hit, .rd_en, .wr_en, .addr,
    .wr_data);
  task chk(input logic [23:0] exp, input logic [23:0] seen, input string w);
    n_tests++;
    if (seen !== exp) begin
      $display("ERROR %s expected %h seen %h", w, exp, seen);
      bad_count++;
    end
  endtask : chk
  task rd(input logic [5:0] a);
    mcu_model_inst.read_reg(a, got, hit);
  endtask : rd
  task give_verdict;
    $display("checks %0d mismatches %0d", n_tests, bad_count);
    if (bad_count == 0 && n_tests > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : give_verdict
  // Watchdog so a stuck run still reaches the verdict
  initial begin
    repeat (5000) @(posedge clk);
    bad_count++;
    give_verdict();
  end
  initial begin
    reset_n = 1'b0;
    crc_valid = 1'b0;
    crc_value = 16'h0000;
    c = 13'h0000;
    bad_count = 0;
    n_tests = 0;
    repeat (6) @(posedge clk);
    reset_n <= 1'b1;
    repeat (3) @(posedge clk);
    rd(6'h03);
    chk(24'h00ffff, got, "checksum reset");
    rd(6'h04);
    chk(24'h0, got, "misc reset");
    chk(24'h1, {23'h0, hit}, "misc reset hit");
    // Eight edges cover the input syncs and band stage
    for (int i = 0; i < 16; i++) begin
      @(posedge clk);
      c <= rows[i][36:24];
      repeat (8) @(posedge clk);
      rd(6'h04);
      chk(rows[i][23:0], got, "misc");
    end
    rd(6'h04);
    chk(24'h001faf, got, "misc reread");
    mcu_model_inst.write_reg(6'h04, 24'hffffff);
    mcu_model_inst.write_reg(6'h03, 24'h000000);
    rd(6'h04);
    chk(24'h001faf, got, "misc after write");
    rd(6'h03);
    chk(24'h00ffff, got, "checksum after write");
    rd(6'h3f);
    chk(24'h0, got | {23'h0, hit}, "unmapped");
    @(posedge clk);
    crc_valid <= 1'b1;
    crc_value <= 16'ha5c3;
    @(posedge clk);
    crc_valid <= 1'b0;
    mcu_model_inst.verify_crc(16'ha5c3, match);
    chk(24'h1, {23'h0, match}, "checksum match");
    rd(status_regs_pkg::INT_STATUS_IDX);
    chk(24'h000020, got, "flag read");
    chk(24'h0, {23'h0, hot_warning_event}, "flag cleared");
    @(posedge clk);
    c <= 13'h1ffd;
    repeat (8) @(posedge clk);
    chk(24'h1, {23'h0, hot_warning_event}, "flag set");
    rd(6'h04);
    chk(24'h001fad, got, "warning low");
    // Second reset in mid-run: outputs clear, checksum back to all ones
    reset_n <= 1'b0;
    repeat (2) @(posedge clk);
    chk(24'h0, rd_data, "rd_data in reset");
    chk(24'h0, {23'h0, hot_warning_event}, "flag in reset");
    reset_n <= 1'b1;
    repeat (3) @(posedge clk);
    rd(6'h03);
    chk(24'h00ffff, got, "checksum after reset");
    repeat (8) @(posedge clk);
    rd(6'h04);
    chk(24'h001fad, got, "misc after reset");
    give_verdict();
  end
endmodule : checksum_and_misc_status_regs_test
`default_nettype wire
